// ---- rtl/crce_top.sv ----
// Programmable check engine with AHB-Lite registers and a scanner input port.
//
// Operation
// [RL1] Accumulator is length field plus one bits; polynomial is that plus two.
// [RL2] Any accumulator width up to 16 bits, polynomial up to 17.
// [RL3] Top and bottom polynomial terms are forced to one by hardware.
// [RL4] Terms between the ends come from the writable polynomial register.
// [RL5] Lowest stored polynomial bit is unimplemented and reads zero.
// [RL6] Words come from software data writes or the memory scanner.
// [RL7] Word width up to 16 bits comes from the data length field.
// [RL8] Data bits above the configured length are ignored.
// [RL9] Each word passes through a shift register into the accumulator.
// [RL10] Order bit clear: most significant bit first, top set by length.
// [RL11] Order bit set: least significant bit first.
// [RL12] Software may seed the accumulator; calculation starts from that value.
// [RL13] High byte first; a low byte write latches the whole word.
// [RL14] One bit per clock; XOR polynomial when top bit XOR data is one.
// [RL15] Data length is bits minus one; busy shows while shifting.
`timescale 1ns/1ns
module crce_top
#(
  parameter int FIFO_DEPTH = 16
) (
  input  wire logic                      hclk,
  input  wire logic                      hresetn,
  input  wire logic                      hsel,
  input  wire logic [31:0]               haddr,
  input  wire logic [1:0]                htrans,
  input  wire logic                      hwrite,
  input  wire logic [2:0]                hsize,
  input  wire logic [31:0]               hwdata,
  input  wire logic                      hready,
  output logic                           hreadyout,
  output logic      [31:0]               hrdata,
  output logic                           hresp,
  input  wire logic                      scan_valid,
  input  wire logic [crce_pkg::CRC_W-1:0] scan_data,
  output logic                           scan_ready,
  output logic                           busy
);
  import crce_pkg::*;

  // Assertions sample on the bus clock and rest while reset is held.
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  localparam int LVL_W = $clog2(FIFO_DEPTH + 1);

  // ----------------------------------------------------------------------
  // State of the block.
  // ----------------------------------------------------------------------
  typedef struct packed {
    crce_state_t       state;
    logic [CRC_W-1:0]  acc;
    logic [CRC_W-1:0]  shreg;
    logic [LEN_W-1:0]  cnt;
    logic [LEN_W-1:0]  poly_length_field;
    logic [LEN_W-1:0]  data_length_field;
    logic              order;
    logic [CRC_W-1:1]  terms;
    logic [BYTE_W-1:0] word_hi;
    logic [BYTE_W-1:0] word_lo;
    logic              ph_wr;
    logic [ADDR_W-1:0] ph_addr;
    logic              hready;
    logic [31:0]       hrdata;
    logic              hresp;
    logic              scan_rdy;
    logic              busy;
  } crce_st_t;

  crce_st_t         st_r;
  crce_st_t         st_nxt;
  logic             fifo_in_valid;
  logic             fifo_in_ready;
  logic [CRC_W-1:0] fifo_in_data;
  logic             fifo_out_valid;
  logic             fifo_out_ready;
  logic [CRC_W-1:0] fifo_out_data;
  logic [LVL_W-1:0] fifo_level;
  logic             sw_push;
  logic             accept;
  logic [CRC_W-1:0] amask;
  logic [CRC_W-1:0] dmask;
  logic [CRC_W-1:0] poly_eff;
  logic             data_bit;
  logic             feedback;
  logic [CRC_W-1:0] acc_step;
  logic [31:0]      rd_mux;

  // Ones in the low len+1 positions.
  function automatic logic [CRC_W-1:0] len_mask(input logic [LEN_W-1:0] len);
    len_mask = FULL_MASK >> (LEN_TOP - len);
  endfunction : len_mask

  // ----------------------------------------------------------------------
  // Word queue between the two sources and the shift engine.
  // ----------------------------------------------------------------------
  crce_fifo #(
    .WIDTH (CRC_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data),
    .level     (fifo_level)
  );

  // Software push is the data phase of a low byte write; it beats the scanner.
  assign sw_push       = st_r.ph_wr && (st_r.ph_addr == OFS_WORD_LOW);      // [RL13]
  assign fifo_in_valid = sw_push || (scan_valid && st_r.scan_rdy);          // [RL6]
  assign fifo_in_data  = sw_push ? {st_r.word_hi, hwdata[BYTE_W-1:0]}       // [RL13]
                                 : scan_data;
  assign fifo_out_ready = (st_r.state == ST_IDLE);
  assign accept        = hsel && htrans[1] && hready;

  // ----------------------------------------------------------------------
  // Check value datapath for one bit.
  // ----------------------------------------------------------------------
  assign amask    = len_mask(st_r.poly_length_field);                                   // [RL1] [RL2]
  assign dmask    = len_mask(st_r.data_length_field);                                   // [RL7] [RL15]
  assign poly_eff = {st_r.terms, 1'b1} & amask;                            // [RL3] [RL4]
  assign data_bit = st_r.order ? st_r.shreg[0]                             // [RL11]
                               : st_r.shreg[st_r.data_length_field];                    // [RL10]
  assign feedback = st_r.acc[st_r.poly_length_field] ^ data_bit;                        // [RL14]
  assign acc_step = ((st_r.acc << 1) ^ (feedback ? poly_eff : ZERO_16)) & amask;

  // Read data mux; bit zero of the polynomial register is not stored.
  always_comb begin
    rd_mux = ZERO_32;
    case (haddr[ADDR_W-1:0])
      OFS_CONTROL_0: begin
        rd_mux[CTL0_ORDER_BIT] = st_r.order;
        rd_mux[CTL0_BUSY_BIT]  = st_r.busy;
        rd_mux[CTL0_FULL_BIT]  = !fifo_in_ready;
      end
      OFS_CONTROL_1: begin
        rd_mux[CTL1_POLY_LENGTH_FIELD_LSB +: LEN_W] = st_r.poly_length_field;
        rd_mux[CTL1_DATA_LENGTH_FIELD_LSB +: LEN_W] = st_r.data_length_field;
      end
      OFS_WORD_LOW:    rd_mux[BYTE_W-1:0] = st_r.word_lo;
      OFS_WORD_HIGH:   rd_mux[BYTE_W-1:0] = st_r.word_hi;
      OFS_POLY_TERMS:  rd_mux[CRC_W-1:0]  = {st_r.terms, 1'b0};            // [RL5]
      OFS_ACCUMULATOR: rd_mux[CRC_W-1:0]  = st_r.acc;
      OFS_SHIFT_VIEW:  rd_mux[CRC_W-1:0]  = st_r.shreg;
      default:         rd_mux = ZERO_32;
    endcase
  end

  // ----------------------------------------------------------------------
  // Next state: bus slave, register writes and shift engine.
  // ----------------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.hresp = 1'b0;
    // Shift engine: load one word, then one bit per clock.
    case (st_r.state)
      ST_IDLE: begin
        if (fifo_out_valid) begin
          st_nxt.shreg = fifo_out_data & dmask;                            // [RL8] [RL9]
          st_nxt.cnt   = st_r.data_length_field;
          st_nxt.state = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        st_nxt.acc   = acc_step;                                           // [RL14]
        st_nxt.shreg = st_r.order ? (st_r.shreg >> 1)                      // [RL11]
                                  : ((st_r.shreg << 1) & dmask);           // [RL10]
        st_nxt.cnt   = st_r.cnt - 1'b1;
        if (st_r.cnt == '0) begin
          st_nxt.state = ST_IDLE;
        end
      end
      default: st_nxt.state = ST_IDLE;
    endcase
    // Data phase of a write.
    if (st_r.ph_wr) begin
      if (sw_push) begin
        if (fifo_in_ready) begin
          st_nxt.word_lo = hwdata[BYTE_W-1:0];
          st_nxt.ph_wr   = 1'b0;
          st_nxt.hready  = 1'b1;
        end
      end else begin
        st_nxt.ph_wr = 1'b0;
        case (st_r.ph_addr)
          OFS_CONTROL_0: st_nxt.order = hwdata[CTL0_ORDER_BIT];
          OFS_CONTROL_1: begin
            st_nxt.poly_length_field = hwdata[CTL1_POLY_LENGTH_FIELD_LSB +: LEN_W];
            st_nxt.data_length_field = hwdata[CTL1_DATA_LENGTH_FIELD_LSB +: LEN_W];
            // A narrower accumulator drops the bits that no longer exist.
            st_nxt.acc  = st_nxt.acc & len_mask(hwdata[CTL1_POLY_LENGTH_FIELD_LSB +: LEN_W]); // [RL1]
          end
          OFS_WORD_HIGH:   st_nxt.word_hi = hwdata[BYTE_W-1:0];
          OFS_POLY_TERMS:  st_nxt.terms   = hwdata[CRC_W-1:1];             // [RL4] [RL5]
          OFS_ACCUMULATOR: st_nxt.acc     = hwdata[CRC_W-1:0] & amask;     // [RL12]
          default: st_nxt.ph_wr = 1'b0;
        endcase
      end
    end
    // Address phase; only a low byte write waits, for room in the queue.
    if (accept) begin
      st_nxt.ph_wr   = hwrite;
      st_nxt.ph_addr = haddr[ADDR_W-1:0];
      st_nxt.hrdata  = hwrite ? ZERO_32 : rd_mux;
      if (hwrite && (haddr[ADDR_W-1:0] == OFS_WORD_LOW)) begin
        st_nxt.hready = 1'b0;
      end
    end
    // Scanner is offered room only with three or more free slots and no software push next.
    st_nxt.scan_rdy = (fifo_level < LVL_W'(FIFO_DEPTH - 2))
                      && !(st_nxt.ph_wr && (st_nxt.ph_addr == OFS_WORD_LOW));
    st_nxt.busy = (st_nxt.state == ST_SHIFT) || fifo_out_valid              // [RL15]
                  || sw_push;
  end

  // State register.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r          <= '0;
      st_r.state    <= ST_IDLE;
      st_r.poly_length_field     <= RST_POLY_LENGTH_FIELD;
      st_r.data_length_field     <= RST_DATA_LENGTH_FIELD;
      st_r.hready   <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign hreadyout  = st_r.hready;
  assign hrdata     = st_r.hrdata;
  assign hresp      = st_r.hresp;
  assign scan_ready = st_r.scan_rdy;
  assign busy       = st_r.busy;

  // ----------------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------------
  a_acc_upper_zero: assert property ((st_r.acc & ~amask) == ZERO_16) // [RL1]
    else $error("Accumulator holds bits above its width.");

  a_poly_ends_set: assert property ( // [RL3]
    poly_eff[0] && amask[st_r.poly_length_field]
      && (st_r.state != ST_SHIFT || acc_step[0] == feedback))
    else $error("Polynomial end terms are not forced.");

  a_poly_lsb_reads: assert property ( // [RL5]
    (accept && !hwrite && haddr[ADDR_W-1:0] == OFS_POLY_TERMS) |=> !hrdata[0])
    else $error("Polynomial register bit zero did not read zero.");

  a_load_masked: assert property ( // [RL8]
    (st_r.state == ST_IDLE && fifo_out_valid)
      |=> (st_r.state == ST_SHIFT) && ((st_r.shreg & ~dmask) == ZERO_16))
    else $error("Loaded word keeps bits above the data length.");

  a_msb_shift: assert property ( // [RL10]
    (st_r.state == ST_SHIFT && !st_r.order && !st_r.ph_wr)
      |=> st_r.shreg == (($past(st_r.shreg) << 1) & dmask))
    else $error("Most significant first shift went wrong.");

  a_lsb_shift: assert property ( // [RL11]
    (st_r.state == ST_SHIFT && st_r.order && !st_r.ph_wr)
      |=> st_r.shreg == ($past(st_r.shreg) >> 1))
    else $error("Least significant first shift went wrong.");

  a_bit_step: assert property ( // [RL14]
    (st_r.state == ST_SHIFT && !st_r.ph_wr) |=> st_r.acc == $past(acc_step))
    else $error("Accumulator did not take one bit step.");

  a_word_length: assert property ( // [RL7]
    (st_r.state == ST_SHIFT && st_r.cnt == '0) |=> st_r.state == ST_IDLE)
    else $error("Shift engine overran the data length.");

  a_busy_shift: assert property ((st_r.state == ST_SHIFT) |-> busy) // [RL15]
    else $error("Busy low while shifting.");

  a_seed_write: assert property ( // [RL12]
    (st_r.ph_wr && st_r.ph_addr == OFS_ACCUMULATOR)
      |=> st_r.acc == ($past(hwdata[CRC_W-1:0]) & $past(amask)))
    else $error("Seed value not taken by the accumulator.");

  a_low_write_push: assert property ( // [RL13]
    (sw_push && fifo_in_ready) |-> fifo_in_valid
      && fifo_in_data == {st_r.word_hi, hwdata[BYTE_W-1:0]} ##1 hreadyout)
    else $error("Low byte write did not queue the full word.");

  a_terms_write: assert property ( // [RL4]
    (st_r.ph_wr && st_r.ph_addr == OFS_POLY_TERMS)
      |=> poly_eff[CRC_W-1:1] == ($past(hwdata[CRC_W-1:1]) & amask[CRC_W-1:1]))
    else $error("Polynomial terms not taken from the written word.");

  a_scan_take: assert property ( // [RL6]
    (scan_valid && scan_ready)
      |-> fifo_in_ready && fifo_in_valid && fifo_in_data == scan_data)
    else $error("Scanner word offered without room in the queue.");

  a_busy_queued: assert property (fifo_out_valid |=> busy) // [RL15]
    else $error("Busy low while a word waits in the queue.");

  a_full_stall: assert property ( // [RL13]
    (st_r.ph_wr && st_r.ph_addr == OFS_WORD_LOW && !fifo_in_ready) |-> !hreadyout)
    else $error("Bus released before the low byte word was queued.");

endmodule : crce_top

// ---- rtl/crce_pkg.sv ----
// Shared constants and types of the programmable check engine.
package crce_pkg;

  // ----------------------------------------------------------------------
  // Register byte offsets on the AHB-Lite slave.
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_CONTROL_0    = 8'h00;
  localparam logic [7:0] OFS_CONTROL_1    = 8'h04;
  localparam logic [7:0] OFS_WORD_LOW     = 8'h08;
  localparam logic [7:0] OFS_WORD_HIGH    = 8'h0C;
  localparam logic [7:0] OFS_POLY_TERMS   = 8'h10;
  localparam logic [7:0] OFS_ACCUMULATOR  = 8'h14;
  localparam logic [7:0] OFS_SHIFT_VIEW   = 8'h18;

  // ----------------------------------------------------------------------
  // Field positions and widths.
  // ----------------------------------------------------------------------
  localparam int          CRC_W           = 16;
  localparam int          LEN_W           = 4;
  localparam int          ADDR_W          = 8;
  localparam int          CTL0_ORDER_BIT  = 0;
  localparam int          CTL0_BUSY_BIT   = 1;
  localparam int          CTL0_FULL_BIT   = 2;
  localparam int          CTL1_POLY_LENGTH_FIELD_LSB   = 0;
  localparam int          CTL1_DATA_LENGTH_FIELD_LSB   = 4;
  localparam int          BYTE_W          = 8;

  // ----------------------------------------------------------------------
  // Reset values and fixed words.
  // ----------------------------------------------------------------------
  localparam logic [3:0]  RST_POLY_LENGTH_FIELD        = 4'hF;
  localparam logic [3:0]  RST_DATA_LENGTH_FIELD        = 4'hF;
  localparam logic [15:0] FULL_MASK       = 16'hFFFF;
  localparam logic [15:0] ZERO_16         = 16'h0000;
  localparam logic [31:0] ZERO_32         = 32'h0000_0000;
  localparam logic [3:0]  LEN_TOP         = 4'hF;
  localparam logic [1:0]  HTRANS_NONSEQ   = 2'h2;

  // ----------------------------------------------------------------------
  // Shift engine states, one-hot.
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b01,
    ST_SHIFT = 2'b10
  } crce_state_t;

endpackage : crce_pkg

// ---- rtl/crce_fifo.sv ----
// Word FIFO with valid and ready on both sides.
`timescale 1ns/1ns
module crce_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16,
  parameter int LVL_W = $clog2(DEPTH + 1),
  parameter int PTR_W = $clog2(DEPTH)
) (
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic      [LVL_W-1:0] level
);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PTR_W-1:0]            wp;
    logic [PTR_W-1:0]            rp;
    logic [LVL_W-1:0]            cnt;
  } crce_fifo_st_t;

  crce_fifo_st_t st_r;
  crce_fifo_st_t st_nxt;
  logic          push;
  logic          pop;

  // Full and empty come straight from the stored word count.
  assign in_ready  = (st_r.cnt != LVL_W'(DEPTH));
  assign out_valid = (st_r.cnt != '0);
  assign out_data  = st_r.mem[st_r.rp];
  assign level     = st_r.cnt;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Pointers wrap at the depth; the count moves only on a lone push or pop.
  always_comb begin
    st_nxt = st_r;
    if (push) begin
      st_nxt.mem[st_r.wp] = in_data;
      st_nxt.wp = (st_r.wp == PTR_W'(DEPTH - 1)) ? '0 : st_r.wp + 1'b1;
    end
    if (pop) begin
      st_nxt.rp = (st_r.rp == PTR_W'(DEPTH - 1)) ? '0 : st_r.rp + 1'b1;
    end
    if (push && !pop) begin
      st_nxt.cnt = st_r.cnt + 1'b1;
    end else if (pop && !push) begin
      st_nxt.cnt = st_r.cnt - 1'b1;
    end
  end

  // State register.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule : crce_fifo

// ---- testbench/crce_scan_model.sv ----
// Behavioural model of the program memory scanner feeding the check engine.
`timescale 1ns/1ns
module crce_scan_model (
  input  wire logic        hclk,
  output logic             scan_valid,
  output logic      [15:0] scan_data,
  input  wire logic        scan_ready
);

  // ----------------------------------------------------------------------
  // Word delivery
  // ----------------------------------------------------------------------

  // Nothing is offered at time zero.
  initial begin
    scan_valid = 1'b0;
    scan_data  = 16'h0000;
  end

  // Offers one word after gap plus one idle edges, so the model can be prompt or slow.
  // The extra edge keeps two calls from driving valid twice in one time step.
  // The word is held until scan_ready is seen high at an edge.
  // Afterwards the data lines show the inverse word, so stale data is never mistaken.
  task automatic send(input logic [15:0] w, input int gap);
    repeat (gap + 1) @(posedge hclk);
    scan_valid <= 1'b1;
    scan_data  <= w;
    do @(posedge hclk); while (scan_ready !== 1'b1);
    scan_valid <= 1'b0;
    scan_data  <= ~w;
  endtask : send

endmodule : crce_scan_model

// ---- testbench/programmable_crc_engine_tb.sv ----
// Self-checking testbench of the check engine over AHB-Lite and the scanner port.
`timescale 1ns/1ns
module programmable_crc_engine_tb;
  import crce_pkg::*;

  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic        scan_valid, scan_ready, busy, cfg_lsb;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [15:0] scan_data, exp_acc, cfg_terms;
  logic [3:0]  cfg_pl, cfg_dl;
  int          miscompares, total_checks, cycle_count;

  // ----------------------------------------------------------------------
  // Design, scanner model, clock and timeout
  // ----------------------------------------------------------------------

  // The single slave drives the bus hready itself.
  crce_top i_crce_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .scan_valid(scan_valid),
    .scan_data(scan_data), .scan_ready(scan_ready), .busy(busy));

  crce_scan_model i_crce_scan_model (.hclk(hclk), .scan_valid(scan_valid),
    .scan_data(scan_data), .scan_ready(scan_ready));

  // Clock at 50 ns period.
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  // A hang is cut short well above the expected run length.
  always @(posedge hclk) begin
    cycle_count <= cycle_count + 1;
    if (cycle_count == 20000) begin
      miscompares++;
      complete_run();
    end
  end

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------

  // Prints the verdict and ends the run.
  task automatic complete_run;
    if (miscompares == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : complete_run

  // Counts a comparison and reports a mismatch at once.
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // One single AHB-Lite transfer; the master waits for hready in both phases.
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
    hsel   <= 1'b1;
    haddr  <= {24'h00_0000, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk("hresp", 32'h0000_0000, {31'h0000_0000, hresp});
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
    logic [31:0] r;
    xfer(1'b0, a, 32'h0000_0000, r);
    chk(nm, exp, r);
  endtask : rd

  // Reference step: one bit a cycle, polynomial folded in when top bit XOR data is one.
  function automatic logic [15:0] ref_crc(input logic [15:0] acc, input logic [15:0] d);
    logic [15:0] poly;
    logic [15:0] mask;
    logic        fb;
    poly = {cfg_terms[15:1], 1'b1};
    mask = 16'hFFFF >> (15 - cfg_pl);
    for (int i = 0; i <= cfg_dl; i++) begin
      fb  = acc[cfg_pl] ^ (cfg_lsb ? d[i] : d[cfg_dl - i]);
      acc = ((acc << 1) ^ (fb ? poly : 16'h0000)) & mask;
    end
    return acc;
  endfunction : ref_crc

  // Sets lengths, order, terms and seed, and the matching expectation.
  task automatic cfg(input logic [3:0] pl, input logic [3:0] dl, input logic lsb,
                     input logic [15:0] terms, input logic [15:0] seed);
    cfg_pl = pl;
    cfg_dl = dl;
    cfg_lsb = lsb;
    cfg_terms = terms;
    exp_acc = seed & (16'hFFFF >> (15 - pl));
    wr(OFS_CONTROL_1, {24'h00_0000, dl, pl});
    wr(OFS_CONTROL_0, {31'h0000_0000, lsb});
    wr(OFS_POLY_TERMS, {16'h0000, terms});
    wr(OFS_ACCUMULATOR, {16'h0000, seed});
  endtask : cfg

  // Queues a word through the data registers, optionally writing the high byte first.
  task automatic push(input logic [15:0] w, input logic hi);
    if (hi) wr(OFS_WORD_HIGH, {24'h00_0000, w[15:8]});
    wr(OFS_WORD_LOW, {24'h00_0000, w[7:0]});
    exp_acc = ref_crc(exp_acc, w);
  endtask : push

  // Waits a bounded time for the engine to drain, then checks the result.
  task automatic wait_idle(input string nm);
    int n;
    n = 0;
    repeat (3) @(posedge hclk);
    while (busy !== 1'b0 && n < 4000) begin
      @(posedge hclk);
      n++;
    end
    chk("busy", 32'h0000_0000, {31'h0000_0000, busy});
    rd(OFS_ACCUMULATOR, {16'h0000, exp_acc}, nm);
  endtask : wait_idle

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------

  initial begin
    miscompares = 0;
    total_checks = 0;
    cycle_count = 0;
    {hsel, hwrite, haddr, hwdata, htrans} = '0;
    hsize = 3'h2;
    hresetn = 1'b0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // Reset values, unmapped place and the unimplemented lowest term.
    rd(OFS_CONTROL_0, 32'h0000_0000, "ctl0 reset");
    rd(OFS_CONTROL_1, 32'h0000_00FF, "ctl1 reset");
    rd(OFS_ACCUMULATOR, 32'h0000_0000, "acc reset");
    wr(OFS_POLY_TERMS, 32'h0000_8005);
    rd(OFS_POLY_TERMS, 32'h0000_8004, "poly low bit");
    wr(8'h1C, 32'hFFFF_FFFF);
    rd(8'h1C, 32'h0000_0000, "unmapped");
    // Known vector, seeded, MSb first, high bytes set above the 8-bit length.
    cfg(4'hF, 4'h7, 1'b0, 16'h1021, 16'hFFFF);
    push(16'hA531, 1'b1);
    rd(OFS_CONTROL_0, 32'h0000_0002, "busy bit");
    chk("busy pin", {31'h0000_0000, busy}, 32'h0000_0001);
    for (int i = 0; i < 8; i++) push({8'hC3, 8'(i + 50)}, 1'b1);
    wait_idle("acc vector");
    chk("acc vector const", {16'h0000, exp_acc}, 32'h0000_29B1);
    // Narrow accumulator, LSb first, full 16-bit words; seed masked to width.
    cfg(4'h7, 4'hF, 1'b1, 16'h0007, 16'hFFFF);
    rd(OFS_ACCUMULATOR, 32'h0000_00FF, "acc masked");
    push(16'h1234, 1'b1);
    push(16'hFEDC, 1'b1);
    wait_idle("acc lsb 8");
    // Odd sizes: 5-bit accumulator and 5-bit words.
    cfg(4'h4, 4'h4, 1'b0, 16'h0014, 16'h0000);
    for (int k = 0; k < 4; k++) push(16'hFFE0 | 16'(k * 7 + 3), 1'b1);
    wait_idle("acc odd");
    // Scanner words, prompt and slow.
    cfg(4'hF, 4'hF, 1'b1, 16'h8005, 16'h0000);
    for (int k = 0; k < 4; k++) begin
      i_crce_scan_model.send(16'h1357 * 16'(k + 1), (k == 2) ? 3 : 0);
      exp_acc = ref_crc(exp_acc, 16'h1357 * 16'(k + 1));
    end
    wait_idle("acc scanner");
    // Back-to-back low writes fill the buffer until the bus stalls, then drain.
    cfg(4'hF, 4'hF, 1'b0, 16'h8005, 16'h1234);
    wr(OFS_WORD_HIGH, 32'h0000_005A);
    for (int k = 0; k < 22; k++) push({8'h5A, 8'(k * 11)}, 1'b0);
    // The last push waited for a slot, so the queue is full and the engine shifting.
    rd(OFS_CONTROL_0, 32'h0000_0006, "ctl0 full");
    wait_idle("acc fill");
    rd(OFS_CONTROL_0, 32'h0000_0000, "ctl0 drained");
    complete_run();
  end

endmodule : programmable_crc_engine_tb
